// >>> rtl/field_counter_pkg.sv
package field_counter_pkg;
	localparam int axis_count = 3;
	localparam int axis_sel_width = 2;
	localparam int cycle_width = 16;
	localparam int legacy_max_cycles = 4096;
	localparam int standard_max_cycles = 65535;
	localparam int result_width = 32;
	localparam logic [15:0] cycle_count_reset = 16'h00c8;
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_forward = 3'b001,
		st_reverse = 3'b010,
		st_finish = 3'b011
	} phase_type;
endpackage

// >>> rtl/field_period_counter.sv
`timescale 1ns/1ps
// What this block does
// [R1] Ground one coil end, drive the other.
// [R2] Count clocks until programmed oscillations complete.
// [R3] Then swap bias ends and repeat run.
// [R4] Result is forward count minus reverse count.
// [R5] Only one axis measured at a time.
// [R6] Each axis keeps its own cycle count.
// [R7] Legacy mode caps cycle count at 4096.
// [R8] Standard mode allows 16-bit cycle counts.
// [R9] Mode strap high selects legacy protocol.
// [R10] Host serial clock at most 1 MHz.
// [R11] Result is signed two's complement.
module field_period_counter #(
	parameter int axes = field_counter_pkg::axis_count,
	parameter int width = field_counter_pkg::result_width
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic mode_strap,
	input wire logic cycle_write,
	input wire logic [field_counter_pkg::axis_sel_width-1:0] cycle_axis,
	input wire logic [field_counter_pkg::cycle_width-1:0] cycle_value,
	input wire logic start,
	input wire logic [field_counter_pkg::axis_sel_width-1:0] start_axis,
	input wire logic [axes-1:0] osc_in,
	output logic [axes-1:0] drive_p,
	output logic [axes-1:0] drive_n,
	output logic [axes-1:0] drive_en,
	output logic busy,
	output logic result_valid,
	output logic [field_counter_pkg::axis_sel_width-1:0] result_axis,
	output logic signed [width-1:0] result,
	output logic legacy_mode
);
	// The axis selects are two bits wide and the counters must hold a long forward run.
	if (axes < 1 || axes > 3 || width < 18) begin : gen_param_check
		$error("field_period_counter: unsupported parameters");
	end

	localparam int cw = field_counter_pkg::cycle_width;
	localparam logic [cw-1:0] legacy_cap = cw'(field_counter_pkg::legacy_max_cycles);
	localparam logic [cw-1:0] standard_cap = cw'(field_counter_pkg::standard_max_cycles);

	field_counter_pkg::phase_type phase_reg;
	field_counter_pkg::phase_type phase_next;
	logic [cw-1:0] cycles_reg [axes];
	logic [field_counter_pkg::axis_sel_width-1:0] axis_reg;
	logic [cw-1:0] osc_left_reg;
	logic [width-1:0] clk_count_reg;
	logic [width-1:0] forward_reg;
	logic strap_seen_reg;
	logic strap_meta_reg;
	logic strap_sync_reg;
	logic [axes-1:0] osc_level;
	logic [axes-1:0] osc_rise;

	// Oscillator comparator outputs are asynchronous to clk.
	// A run only sees rises two edges late; the reverse run also starts on a late rise, so only the forward count carries that lag.
	genvar g;
	generate
		for (g = 0; g < axes; g = g + 1) begin : gen_sync
			osc_edge_sync osc_edge_sync_inst (
				.clk(clk),
				.resetn(resetn),
				.async_in(osc_in[g]),
				.level_out(osc_level[g]),
				.rise_pulse(osc_rise[g])
			);
		end
	endgenerate

	// Strap is caught after reset release; a strap change needs a new reset.
	wire strap_capture = !strap_seen_reg;
	wire [cw-1:0] mode_cap = legacy_mode ? legacy_cap : standard_cap; // R7 R8
	wire [cw-1:0] cycle_clamped = (cycle_value > mode_cap) ? mode_cap : cycle_value; // R7 R8
	wire axis_ok = 32'(start_axis) < axes;
	wire cycle_axis_ok = 32'(cycle_axis) < axes;
	wire accept_start = (phase_reg == field_counter_pkg::st_idle) && start && axis_ok; // R5
	// An out-of-range axis never indexes past the table, even while it is refused.
	wire [field_counter_pkg::axis_sel_width-1:0] start_index = axis_ok ? start_axis : '0;
	wire [cw-1:0] sel_cycles = cycles_reg[start_index]; // R6
	wire run_active = (phase_reg == field_counter_pkg::st_forward) ||
		(phase_reg == field_counter_pkg::st_reverse);
	// Drive follows the phase being entered, so enable and bias change on one edge.
	wire next_active = (phase_next == field_counter_pkg::st_forward) ||
		(phase_next == field_counter_pkg::st_reverse);
	wire [field_counter_pkg::axis_sel_width-1:0] run_axis = accept_start ? start_axis : axis_reg;
	// Only the selected axis can end a run; the idle axes stay undriven.
	wire sel_rise = osc_rise[axis_reg];
	wire run_done = run_active && sel_rise && (osc_left_reg <= cw'(1)); // R2
	wire signed [width-1:0] difference = $signed(forward_reg) - $signed(clk_count_reg); // R4 R11

	// Finish lasts one cycle so the result and its valid pulse leave together.
	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			field_counter_pkg::st_idle: begin
				if (accept_start) begin
					phase_next = field_counter_pkg::st_forward;
				end
			end
			field_counter_pkg::st_forward: begin
				if (run_done) begin
					phase_next = field_counter_pkg::st_reverse; // R3
				end
			end
			field_counter_pkg::st_reverse: begin
				if (run_done) begin
					phase_next = field_counter_pkg::st_finish;
				end
			end
			default: begin
				phase_next = field_counter_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			phase_reg <= field_counter_pkg::st_idle;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// The strap is a pin. Its two stages are left unreset so that they settle while
	// reset is held; a reset shorter than two clocks may catch the old strap level.
	always_ff @(posedge clk) begin
		strap_meta_reg <= mode_strap;
		strap_sync_reg <= strap_meta_reg;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			strap_seen_reg <= 1'b0;
			legacy_mode <= 1'b0;
		end else if (strap_capture) begin
			strap_seen_reg <= 1'b1;
			legacy_mode <= strap_sync_reg; // R9
		end
	end

	// Writes outside the axis range are dropped rather than folded onto a real axis.
	generate
		for (g = 0; g < axes; g = g + 1) begin : gen_cycles
			always_ff @(posedge clk) begin
				if (!resetn) begin
					cycles_reg[g] <= field_counter_pkg::cycle_count_reset;
				end else if (cycle_write && cycle_axis_ok && 32'(cycle_axis) == g) begin
					cycles_reg[g] <= cycle_clamped; // R6
				end
			end
		end
	endgenerate

	// A zero cycle count is run as one oscillation so every run terminates.
	// The completing edge is counted in both runs, so the offsets cancel in the difference.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			axis_reg <= '0;
			osc_left_reg <= '0;
			clk_count_reg <= '0;
			forward_reg <= '0;
		end else if (accept_start) begin
			axis_reg <= start_axis;
			osc_left_reg <= sel_cycles;
			clk_count_reg <= '0;
		end else if (run_active) begin
			if (run_done) begin
				if (phase_reg == field_counter_pkg::st_forward) begin
					forward_reg <= clk_count_reg + 1'b1;
					osc_left_reg <= cycles_reg[axis_reg]; // R3
					clk_count_reg <= '0;
				end else begin
					clk_count_reg <= clk_count_reg + 1'b1;
				end
			end else begin
				clk_count_reg <= clk_count_reg + 1'b1; // R2
				if (sel_rise) begin
					osc_left_reg <= osc_left_reg - 1'b1;
				end
			end
		end
	end

	// Drive follows the synchronised comparator: charge until it trips, then discharge.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			drive_p <= '0;
			drive_n <= '0;
			drive_en <= '0;
		end else begin
			for (int i = 0; i < axes; i++) begin
				drive_en[i] <= next_active && (32'(run_axis) == i); // R5
				if (phase_next == field_counter_pkg::st_forward && 32'(run_axis) == i) begin
					drive_p[i] <= ~osc_level[i]; // R1
					drive_n[i] <= 1'b0;
				end else if (phase_next == field_counter_pkg::st_reverse &&
						32'(run_axis) == i) begin
					drive_p[i] <= 1'b0; // R3
					drive_n[i] <= ~osc_level[i];
				end else begin
					drive_p[i] <= 1'b0;
					drive_n[i] <= 1'b0;
				end
			end
		end
	end

	// Busy falls on the edge that raises result_valid, so a new start may follow at once.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			busy <= 1'b0;
			result_valid <= 1'b0;
			result_axis <= '0;
			result <= '0;
		end else begin
			busy <= (phase_next != field_counter_pkg::st_idle);
			result_valid <= (phase_reg == field_counter_pkg::st_finish);
			if (phase_reg == field_counter_pkg::st_finish) begin
				result <= difference; // R4 R11
				result_axis <= axis_reg;
			end
		end
	end
endmodule

// >>> rtl/osc_edge_sync.sv
`timescale 1ns/1ps
module osc_edge_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic async_in,
	output logic level_out,
	output logic rise_pulse
);
	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end
	assign level_out = stage2_reg;
	assign rise_pulse = stage2_reg & ~stage3_reg;
endmodule

// >>> tb/count_properties.sv
`timescale 1ns/1ps
module count_properties #(
	parameter int axes = 3,
	parameter int width = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic mode_strap,
	input wire logic [axes-1:0] drive_p,
	input wire logic [axes-1:0] drive_n,
	input wire logic [axes-1:0] drive_en,
	input wire logic busy,
	input wire logic result_valid,
	input wire logic signed [width-1:0] result,
	input wire logic legacy_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_ONE: assert property ($onehot0(drive_en)) else $error("two axes");
	AST_IDLE: assert property (!busy |-> drive_en == '0) else $error("idle drive");
	AST_GND: assert property ((drive_p & drive_n) == '0) else $error("both ends");
	AST_OFF: assert property (((drive_p | drive_n) & ~drive_en) == '0)
		else $error("stray drive");
	AST_RISE: assert property ($rose(busy) |-> $onehot(drive_en)) else $error("no axis");
	AST_PULSE: assert property (result_valid |=> !result_valid) else $error("pulse");
	AST_DONE: assert property ($fell(busy) |-> result_valid) else $error("done");
	AST_HOLD: assert property ($changed(result) |-> result_valid) else $error("hold");
	AST_MODE: assert property ($past(resetn, 2) |-> legacy_mode == mode_strap)
		else $error("mode");
	cover property (result_valid && result < 0);
	cover property (result_valid && result > 0);
	cover property (drive_n != '0);
endmodule

// >>> tb/inductive_field_period_counter_bench.sv
`timescale 1ns/1ps
bind field_period_counter count_properties #(.axes(axes), .width(width)) count_properties_inst (
	.clk(clk),
	.resetn(resetn),
	.mode_strap(mode_strap),
	.drive_p(drive_p),
	.drive_n(drive_n),
	.drive_en(drive_en),
	.busy(busy),
	.result_valid(result_valid),
	.result(result),
	.legacy_mode(legacy_mode)
);
module inductive_field_period_counter_bench;
	logic clk = 1'h0, resetn = 1'h0, mode_strap = 1'h0, cycle_write = 1'h0, start = 1'h0;
	logic busy, result_valid, legacy_mode;
	logic [1:0] cycle_axis = 2'h0, start_axis = 2'h0, result_axis;
	logic [15:0] cycle_value = 16'h0, n = 16'h1;
	logic [7:0] hf = 8'h2, hr = 8'h2;
	logic [2:0] osc_in, drive_p, drive_n, drive_en;
	logic signed [31:0] result;
	int n_errors = 0, num_checks = 0, nv[3] = '{0, 200, 0}, qe[$];
	always #10 clk = ~clk;
	field_period_counter field_period_counter_inst (
		.clk(clk),
		.resetn(resetn),
		.mode_strap(mode_strap),
		.cycle_write(cycle_write),
		.cycle_axis(cycle_axis),
		.cycle_value(cycle_value),
		.start(start),
		.start_axis(start_axis),
		.osc_in(osc_in),
		.drive_p(drive_p),
		.drive_n(drive_n),
		.drive_en(drive_en),
		.busy(busy),
		.result_valid(result_valid),
		.result_axis(result_axis),
		.result(result),
		.legacy_mode(legacy_mode)
	);
	sensor_osc_model sensor_osc_model_inst (
		.clk(clk),
		.drive_en(drive_en),
		.n(n),
		.hf(hf),
		.hr(hr),
		.osc_in(osc_in)
	);
	task automatic chk(logic c, string m);
		num_checks++;
		if (c !== 1'h1) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic results;
		$display("%0d checks, %0d errors", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic op(logic w, logic [1:0] a, logic [15:0] v);
		@(posedge clk);
		cycle_write <= w;
		start <= !w;
		cycle_axis <= a;
		start_axis <= a;
		cycle_value <= v;
		@(posedge clk);
		cycle_write <= 1'h0;
		start <= 1'h0;
	endtask
	// Slack in the count covers the oscillator synchroniser delay.
	// A host on a serial link of at most 1 MHz needs 50 of our clocks per command.
	task automatic meas(logic [1:0] a, int f, int r);
		int k;
		k = nv[a] == 0 ? 1 : nv[a];
		repeat (50) @(posedge clk);
		@(posedge clk);
		hf <= 8'(f);
		hr <= 8'(r);
		n <= 16'(k);
		qe.push_back(((2 * k - 1) * f - 2 * k * r) * 4 + a);
		op(1'h0, a, 16'h0);
		op(1'h0, a + 2'h1, 16'h0);
		repeat (40000) if (busy !== 1'h0) @(negedge clk);
		chk(busy === 1'h0, "hang");
		if (busy !== 1'h0) results();
		$display("axis %0d done", a);
	endtask
	always @(negedge clk)
		if (resetn && result_valid === 1'h1) begin
			chk(qe.size() > 0 && result_axis === 2'(qe[0]), "axis");
			chk(result - (qe[0] >>> 2) inside {[-2:6]}, "count");
			void'(qe.pop_front());
		end
	initial begin
		void'($urandom(88444));
		repeat (20) @(posedge clk);
		resetn <= 1'h1;
		@(negedge clk);
		chk({busy, result_valid, drive_en, result, legacy_mode} === '0, "reset");
		meas(2'h1, 3, 2);
		for (int i = 0; i < 3; i++) begin
			nv[i] = $urandom_range(8);
			op(1'h1, 2'(i), 16'(nv[i]));
		end
		op(1'h1, 2'h3, 16'h9);
		op(1'h0, 2'h3, 16'h0);
		@(negedge clk);
		chk(busy === 1'h0, "axis 3");
		for (int j = 0; j < 6; j++)
			meas(2'(j % 3), $urandom_range(6, 2), $urandom_range(6, 2));
		op(1'h1, 2'h2, 16'h1388);
		nv[2] = 5000;
		meas(2'h2, 2, 1);
		@(posedge clk);
		resetn <= 1'h0;
		mode_strap <= 1'h1;
		repeat (20) @(posedge clk);
		resetn <= 1'h1;
		repeat (3) @(negedge clk);
		chk(legacy_mode === 1'h1, "strap");
		op(1'h1, 2'h0, 16'h1068);
		nv[0] = 4096;
		meas(2'h0, 2, 1);
		repeat (2) @(posedge clk);
		chk(qe.size() == 0, "lost");
		results();
	end
endmodule

// >>> tb/sensor_osc_model.sv
`timescale 1ns/1ps
module sensor_osc_model (
	input wire logic clk,
	input wire logic [2:0] drive_en,
	input wire logic [15:0] n,
	input wire logic [7:0] hf,
	input wire logic [7:0] hr,
	output logic [2:0] osc_in
);
	logic osc_reg = 1'h0;
	logic [7:0] t_reg;
	logic [15:0] k_reg;
	// Half periods turn to hr after the n-th rise, when the bias swaps.
	assign osc_in = drive_en & {3{osc_reg}};
	always @(posedge clk) begin
		t_reg <= t_reg + 8'h1;
		if (drive_en == 3'h0) begin
			osc_reg <= 1'h0;
			t_reg <= 8'h1;
			k_reg <= 16'h0;
		end else if (t_reg >= (k_reg < n ? hf : hr)) begin
			osc_reg <= ~osc_reg;
			t_reg <= 8'h1;
			k_reg <= k_reg + 16'(!osc_reg);
		end
	end
endmodule
